// ### design/dmpm_top.sv
// Mute and power-state manager of a stereo audio DAC
`timescale 1ns/100ps

// Contract
// RULE_01: 1024 zero frames force analog mute
// RULE_02: Clock error or halt enters stand-by
// RULE_03: Clocks low over 1 s: power-down
// RULE_04: Valid clocks return: power up automatically
// RULE_05: Mute pin falls: -1dB per sample, 104
// RULE_06: Mute pin rises: +1dB per sample, 104
// RULE_07: Fall of 6ms or more: guard mode
// RULE_08: Guard: upper level mutes, lower shuts down
// RULE_09: Pin low: ramp then hard mute, bounded
// RULE_10: Clock error: internal tick, ramp, hard mute
// RULE_11: Host lowers mute pin before power removal
// RULE_12: Host stops clocks 3ms before power-down
// RULE_13: Pin change mid-ramp reverses from current step
module dmpm_top #(
  parameter int unsigned HALT_CYCLES_P = dmpm_pkg::HALT_CYCLES,
  parameter int unsigned GUARD_FALL_CYCLES_P = dmpm_pkg::GUARD_FALL_CYCLES,
  parameter int unsigned HARD_MUTE_CYCLES_P = dmpm_pkg::HARD_MUTE_CYCLES,
  parameter int unsigned FRAME_RATE_CLOCK_TIMEOUT_CYCLES_P = dmpm_pkg::FRAME_RATE_CLOCK_TIMEOUT_CYCLES,
  parameter int unsigned INT_OSC_CYCLES_P = dmpm_pkg::INT_OSC_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Pins from the audio source
  input wire logic sys_clock_i,
  input wire logic serial_bit_clock_i,
  input wire logic frame_rate_clock_i,
  input wire logic soft_mute_n_i,
  // Level comparators on the mute pin, high while the pin is above the level
  input wire logic guard_above_upper_i,
  input wire logic guard_above_lower_i,
  // Deserialised samples from logic on mclk_i
  input wire logic [31:0] sample_left_i,
  input wire logic [31:0] sample_right_i,
  // Toward the DAC datapath
  output logic [31:0] hold_left_o,
  output logic [31:0] hold_right_o,
  output logic [6:0] atten_db_o,
  output logic sample_tick_o,
  output logic internal_osc_sel_o,
  output logic analog_mute_o,
  // Power controls and status
  output logic dac_power_on_o,
  output logic line_driver_on_o,
  output logic charge_pump_on_o,
  output logic bias_ref_on_o,
  output logic undervoltage_guard_mode_o,
  output dmpm_pkg::dmpm_pwr_t power_state_o
);
  import dmpm_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_meta_r;
  logic [PIN_COUNT-1:0] pin_sync_r;
  logic [PIN_COUNT-1:0] pin_prev_r;

  assign pin_raw = {guard_above_lower_i, guard_above_upper_i, soft_mute_n_i,
                    frame_rate_clock_i, serial_bit_clock_i, sys_clock_i};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          pin_meta_r[gi] <= 1'b0;
          pin_sync_r[gi] <= 1'b0;
          pin_prev_r[gi] <= 1'b0;
        end else begin
          pin_meta_r[gi] <= pin_raw[gi];
          pin_sync_r[gi] <= pin_meta_r[gi];
          pin_prev_r[gi] <= pin_sync_r[gi];
        end
      end
    end
  endgenerate

  logic sck_edge;
  logic bck_rise;
  logic frame_rate_clock_edge;
  logic frame_tick;
  logic smt_high;
  logic upper_ok;
  logic lower_ok;

  assign sck_edge = pin_sync_r[PIN_SCK] ^ pin_prev_r[PIN_SCK];
  assign bck_rise = pin_sync_r[PIN_BCK] & ~pin_prev_r[PIN_BCK];
  assign frame_rate_clock_edge = pin_sync_r[PIN_FRAME_RATE_CLOCK] ^ pin_prev_r[PIN_FRAME_RATE_CLOCK];
  assign frame_tick = pin_sync_r[PIN_FRAME_RATE_CLOCK] & ~pin_prev_r[PIN_FRAME_RATE_CLOCK];
  assign smt_high = pin_sync_r[PIN_SMT];
  assign upper_ok = pin_sync_r[PIN_UPPER];
  assign lower_ok = pin_sync_r[PIN_LOWER];

  //////////////////////////////////////////////////////////////////////////////
  // Clock monitor
  logic [31:0] sck_gap_r, sck_gap_nxt;
  logic [31:0] bck_gap_r, bck_gap_nxt;
  logic [31:0] frame_rate_clock_gap_r, frame_rate_clock_gap_nxt;
  logic [31:0] halt_cnt_r, halt_cnt_nxt;
  logic [7:0] bck_in_frame_r, bck_in_frame_nxt;
  logic [2:0] bad_frames_r, bad_frames_nxt;
  logic [31:0] osc_cnt_r, osc_cnt_nxt;
  logic clk_err;
  logic halt_long;
  logic osc_tick;
  logic ratio_ok;

  assign ratio_ok = (bck_in_frame_r == BCK_PER_FRAME_A) || (bck_in_frame_r == BCK_PER_FRAME_B) ||
                    (bck_in_frame_r == BCK_PER_FRAME_C);
  // Edge gaps start saturated so a device without clocks reports an error
  assign clk_err = (sck_gap_r >= SCK_TIMEOUT_CYCLES) || (bck_gap_r >= BCK_TIMEOUT_CYCLES) ||
                   (frame_rate_clock_gap_r >= FRAME_RATE_CLOCK_TIMEOUT_CYCLES_P) || (bad_frames_r > BAD_FRAME_LIMIT); // RULE_02
  assign halt_long = halt_cnt_r > HALT_CYCLES_P; // RULE_03
  assign osc_tick = (osc_cnt_r == CNT_ZERO);

  always_comb begin
    sck_gap_nxt = sck_edge ? CNT_ZERO : sck_gap_r + {31'h0, sck_gap_r != CNT_SATURATED};
    bck_gap_nxt = bck_rise ? CNT_ZERO : bck_gap_r + {31'h0, bck_gap_r != CNT_SATURATED};
    frame_rate_clock_gap_nxt = frame_rate_clock_edge ? CNT_ZERO : frame_rate_clock_gap_r + {31'h0, frame_rate_clock_gap_r != CNT_SATURATED};
    // Both serial clocks parked low
    if (!pin_sync_r[PIN_BCK] && !pin_sync_r[PIN_FRAME_RATE_CLOCK]) begin
      halt_cnt_nxt = halt_cnt_r + {31'h0, halt_cnt_r != CNT_SATURATED}; // RULE_03
    end else begin
      halt_cnt_nxt = CNT_ZERO;
    end
    bck_in_frame_nxt = bck_in_frame_r;
    bad_frames_nxt = bad_frames_r;
    if (frame_tick) begin
      bck_in_frame_nxt = 8'h00;
      if (ratio_ok) begin
        bad_frames_nxt = 3'h0;
      end else if (bad_frames_r <= BAD_FRAME_LIMIT) begin
        bad_frames_nxt = bad_frames_r + 3'h1;
      end
    end else if (bck_rise && bck_in_frame_r != 8'hFF) begin
      bck_in_frame_nxt = bck_in_frame_r + 8'h01;
    end
    // Free-running stand-in for the frame clock while the clocks are bad
    if (osc_cnt_r >= INT_OSC_CYCLES_P - 1) begin
      osc_cnt_nxt = CNT_ZERO;
    end else begin
      osc_cnt_nxt = osc_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_gap_r <= CNT_SATURATED;
      bck_gap_r <= CNT_SATURATED;
      frame_rate_clock_gap_r <= CNT_SATURATED;
      halt_cnt_r <= CNT_ZERO;
      bck_in_frame_r <= 8'h00;
      bad_frames_r <= 3'h0;
      osc_cnt_r <= CNT_ZERO;
    end else begin
      sck_gap_r <= sck_gap_nxt;
      bck_gap_r <= bck_gap_nxt;
      frame_rate_clock_gap_r <= frame_rate_clock_gap_nxt;
      halt_cnt_r <= halt_cnt_nxt;
      bck_in_frame_r <= bck_in_frame_nxt;
      bad_frames_r <= bad_frames_nxt;
      osc_cnt_r <= osc_cnt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Undervoltage guard: the pin's fall time is measured from the upper level
  logic [31:0] fall_cnt_r, fall_cnt_nxt;
  logic fast_fall_r, fast_fall_nxt;
  logic guard_r, guard_nxt;
  logic guard_shutdown;

  assign guard_shutdown = guard_r & ~lower_ok; // RULE_08

  always_comb begin
    fall_cnt_nxt = fall_cnt_r;
    fast_fall_nxt = fast_fall_r;
    guard_nxt = guard_r;
    if (upper_ok && smt_high) begin
      fall_cnt_nxt = CNT_ZERO;
      fast_fall_nxt = 1'b0;
      guard_nxt = 1'b0;
    end else if (!guard_r) begin
      if (fall_cnt_r != CNT_SATURATED) begin
        fall_cnt_nxt = fall_cnt_r + 32'h1;
      end
      // A quick edge is a plain mute command and never arms the guard
      if (!smt_high && fall_cnt_r < GUARD_FALL_CYCLES_P) begin
        fast_fall_nxt = 1'b1;
      end
      if (!fast_fall_r && smt_high && fall_cnt_r + 32'h1 >= GUARD_FALL_CYCLES_P) begin
        guard_nxt = 1'b1; // RULE_07
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fall_cnt_r <= CNT_ZERO;
      fast_fall_r <= 1'b0;
      guard_r <= 1'b0;
    end else begin
      fall_cnt_r <= fall_cnt_nxt;
      fast_fall_r <= fast_fall_nxt;
      guard_r <= guard_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power state, soft ramp, zero detect and hard mute
  dmpm_pwr_t state_r, state_nxt;
  logic [31:0] up_cnt_r, up_cnt_nxt;
  logic [6:0] atten_r, atten_nxt;
  logic [10:0] zero_cnt_r, zero_cnt_nxt;
  logic [31:0] hard_cnt_r, hard_cnt_nxt;
  logic [31:0] hold_l_r, hold_l_nxt;
  logic [31:0] hold_r_r, hold_r_nxt;
  logic tick;
  logic mute_req;
  logic zero_mute;
  logic hard_done;
  logic powered;
  logic amute_r, amute_nxt;
  logic tick_r;

  // Upper level low also covers the guard's soft mute; it tracks the pin otherwise
  assign mute_req = ~smt_high | ~upper_ok | guard_shutdown | (state_r != PWR_ACTIVE); // RULE_08
  assign tick = clk_err ? osc_tick : frame_tick; // RULE_10
  assign zero_mute = (zero_cnt_r == ZERO_FRAMES_MAX);
  assign hard_done = hard_cnt_r >= HARD_MUTE_CYCLES_P;
  assign powered = (state_r == PWR_ACTIVE) || (state_r == PWR_DRAIN) || (state_r == PWR_STARTUP);

  always_comb begin
    state_nxt = state_r;
    up_cnt_nxt = CNT_ZERO;
    case (state_r)
      PWR_ACTIVE: begin
        if (halt_long) begin
          state_nxt = PWR_DOWN; // RULE_03
        end else if (clk_err) begin
          state_nxt = PWR_DRAIN; // RULE_10
        end else if (guard_shutdown) begin
          state_nxt = PWR_STANDBY; // RULE_08
        end
      end
      PWR_DRAIN: begin
        // Keep the converter running until the ramp reaches silence
        if (halt_long) begin
          state_nxt = PWR_DOWN;
        end else if (atten_r == ATT_FULL) begin
          state_nxt = PWR_STANDBY; // RULE_02
        end
      end
      PWR_STANDBY: begin
        if (halt_long) begin
          state_nxt = PWR_DOWN; // RULE_03
        end else if (!clk_err && !guard_shutdown) begin
          state_nxt = PWR_STARTUP; // RULE_04
        end
      end
      PWR_DOWN: begin
        if (!clk_err) begin
          state_nxt = PWR_STARTUP; // RULE_04
        end
      end
      PWR_STARTUP: begin
        up_cnt_nxt = up_cnt_r + 32'h1;
        if (clk_err || guard_shutdown) begin
          state_nxt = PWR_STANDBY;
        end else if (up_cnt_r >= POWERUP_CYCLES - 1) begin
          state_nxt = PWR_ACTIVE;
        end
      end
      default: begin
        state_nxt = PWR_DOWN;
      end
    endcase
  end

  always_comb begin
    atten_nxt = atten_r;
    // One step per sample; direction follows the request, so a mid-ramp change turns back
    if (!powered || state_r == PWR_STARTUP) begin
      atten_nxt = ATT_FULL;
    end else if (tick) begin
      if (mute_req && atten_r != ATT_FULL) begin
        atten_nxt = atten_r + 7'h01; // RULE_05 RULE_13
      end else if (!mute_req && atten_r != ATT_NONE) begin
        atten_nxt = atten_r - 7'h01; // RULE_06 RULE_13
      end
    end
    zero_cnt_nxt = zero_cnt_r;
    hold_l_nxt = hold_l_r;
    hold_r_nxt = hold_r_r;
    // Samples are latched only on true frames; on a clock error the last one is held
    if (frame_tick && !clk_err) begin
      hold_l_nxt = sample_left_i;
      hold_r_nxt = sample_right_i;
      if (sample_left_i != 32'h0 || sample_right_i != 32'h0) begin
        zero_cnt_nxt = 11'h000;
      end else if (!zero_mute) begin
        zero_cnt_nxt = zero_cnt_r + 11'h001; // RULE_01
      end
    end
    // Hard mute follows the ramp's end after a fixed settling delay
    if (mute_req && atten_r == ATT_FULL) begin
      hard_cnt_nxt = hard_done ? hard_cnt_r : hard_cnt_r + 32'h1; // RULE_09
    end else begin
      hard_cnt_nxt = CNT_ZERO;
    end
    amute_nxt = zero_mute || hard_done || guard_shutdown || !powered ||
                (state_r == PWR_STARTUP); // RULE_01 RULE_09 RULE_08 RULE_10
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= PWR_DOWN;
      up_cnt_r <= CNT_ZERO;
      atten_r <= ATT_FULL;
      zero_cnt_r <= 11'h000;
      hard_cnt_r <= CNT_ZERO;
      hold_l_r <= 32'h0;
      hold_r_r <= 32'h0;
      amute_r <= 1'b1;
      tick_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      up_cnt_r <= up_cnt_nxt;
      atten_r <= atten_nxt;
      zero_cnt_r <= zero_cnt_nxt;
      hard_cnt_r <= hard_cnt_nxt;
      hold_l_r <= hold_l_nxt;
      hold_r_r <= hold_r_nxt;
      amute_r <= amute_nxt;
      tick_r <= tick;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign hold_left_o = hold_l_r;
  assign hold_right_o = hold_r_r;
  assign atten_db_o = atten_r;
  assign sample_tick_o = tick_r;
  assign internal_osc_sel_o = (state_r == PWR_DRAIN); // RULE_10
  assign analog_mute_o = amute_r;
  assign dac_power_on_o = powered; // RULE_02
  assign line_driver_on_o = powered; // RULE_02
  assign charge_pump_on_o = (state_r != PWR_DOWN); // RULE_03
  assign bias_ref_on_o = (state_r != PWR_DOWN); // RULE_03
  assign undervoltage_guard_mode_o = guard_r;
  assign power_state_o = state_r;

endmodule

// ### design/dmpm_pkg.sv
// Package: constants, timing and state types of the DAC mute and power manager
package dmpm_pkg;

  // Core clock rate
  localparam int unsigned CLK_MHZ = 250;

  //////////////////////////////////////////////////////////////////////////////
  // Zero data detect
  localparam int unsigned ZERO_FRAMES = 1024;
  localparam logic [10:0] ZERO_FRAMES_MAX = 11'h400;

  //////////////////////////////////////////////////////////////////////////////
  // Soft ramp: one dB step per sample period, 104 steps from 0 dBFS to silence
  localparam int unsigned RAMP_STEPS = 104;
  localparam logic [6:0] ATT_FULL = 7'h68;
  localparam logic [6:0] ATT_NONE = 7'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Times in their own units and derived cycle counts
  localparam int unsigned HALT_TIME_MS = 1000;
  localparam int unsigned HALT_CYCLES = HALT_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned GUARD_FALL_MS = 6;
  localparam int unsigned GUARD_FALL_CYCLES = GUARD_FALL_MS * CLK_MHZ * 1000;
  localparam int unsigned HARD_MUTE_NS = 200000;
  localparam int unsigned HARD_MUTE_CYCLES = (HARD_MUTE_NS * CLK_MHZ) / 1000;
  localparam int unsigned SCK_TIMEOUT_NS = 4000;
  localparam int unsigned SCK_TIMEOUT_CYCLES = (SCK_TIMEOUT_NS * CLK_MHZ) / 1000;
  localparam int unsigned BCK_TIMEOUT_NS = 8000;
  localparam int unsigned BCK_TIMEOUT_CYCLES = (BCK_TIMEOUT_NS * CLK_MHZ) / 1000;
  localparam int unsigned FRAME_RATE_CLOCK_TIMEOUT_NS = 130000;
  localparam int unsigned FRAME_RATE_CLOCK_TIMEOUT_CYCLES = (FRAME_RATE_CLOCK_TIMEOUT_NS * CLK_MHZ) / 1000;
  localparam int unsigned INT_OSC_NS = 20833;
  localparam int unsigned INT_OSC_CYCLES = (INT_OSC_NS * CLK_MHZ) / 1000;
  localparam int unsigned POWERUP_NS = 10000;
  localparam int unsigned POWERUP_CYCLES = (POWERUP_NS * CLK_MHZ + 999) / 1000;

  //////////////////////////////////////////////////////////////////////////////
  // Bit clocks per frame that count as a valid ratio, and the tolerated bad frames
  localparam logic [7:0] BCK_PER_FRAME_A = 8'h20;
  localparam logic [7:0] BCK_PER_FRAME_B = 8'h30;
  localparam logic [7:0] BCK_PER_FRAME_C = 8'h40;
  localparam logic [2:0] BAD_FRAME_LIMIT = 3'h4;

  // Reset values
  localparam logic [31:0] CNT_SATURATED = 32'hFFFF_FFFF;
  localparam logic [31:0] CNT_ZERO = 32'h0000_0000;

  // Synchroniser lanes
  localparam int unsigned PIN_SCK = 0;
  localparam int unsigned PIN_BCK = 1;
  localparam int unsigned PIN_FRAME_RATE_CLOCK = 2;
  localparam int unsigned PIN_SMT = 3;
  localparam int unsigned PIN_UPPER = 4;
  localparam int unsigned PIN_LOWER = 5;
  localparam int unsigned PIN_COUNT = 6;

  typedef enum logic [2:0] {
    PWR_DOWN,
    PWR_STANDBY,
    PWR_STARTUP,
    PWR_ACTIVE,
    PWR_DRAIN
  } dmpm_pwr_t;

endpackage

// ### test/dmpm_checker_sva.sv
// Checker: port-level properties of the mute and power manager
`timescale 1ns/100ps
////////////////////////////////////////
module dmpm_checker
  import dmpm_pkg::*;
#(
  parameter int unsigned HARD_MUTE_CYCLES_P = 50
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Pins
  input wire logic soft_mute_n_i,
  input wire logic guard_above_lower_i,
  // Outputs watched
  input wire logic [6:0] atten_db_o,
  input wire logic sample_tick_o,
  input wire logic internal_osc_sel_o,
  input wire logic analog_mute_o,
  input wire logic dac_power_on_o,
  input wire logic line_driver_on_o,
  input wire logic charge_pump_on_o,
  input wire logic bias_ref_on_o,
  input wire logic undervoltage_guard_mode_o,
  input wire dmpm_pkg::dmpm_pwr_t power_state_o
);
  import dmpm_pkg::*;
  // Margin covers pin sync and the registered mute
  localparam int HM_MAX = HARD_MUTE_CYCLES_P + 6;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  AST_RAMP_STEP:
    assert property ($changed(atten_db_o) && power_state_o == PWR_ACTIVE && $past(power_state_o) == PWR_ACTIVE
      |-> (sample_tick_o || $past(sample_tick_o))
      && (atten_db_o - $past(atten_db_o) == 7'h01 || $past(atten_db_o) - atten_db_o == 7'h01))
    else $error("attenuation moved off a single tick step");
  AST_DRAIN_DONE:
    assert property ($fell(internal_osc_sel_o) && power_state_o == PWR_STANDBY
      |-> atten_db_o == ATT_FULL ##[0:2] analog_mute_o)
    else $error("drain left before silence and hard mute");
  AST_DRAIN_TICK_GAP:
    assert property (internal_osc_sel_o && sample_tick_o |=> !sample_tick_o [*8])
    else $error("internal ticks too close");
  AST_STANDBY_PWR:
    assert property (power_state_o == PWR_STANDBY
      |-> !dac_power_on_o && !line_driver_on_o && charge_pump_on_o && bias_ref_on_o)
    else $error("standby power outputs wrong");
  AST_DOWN_PWR:
    assert property (power_state_o == PWR_DOWN
      |-> !charge_pump_on_o && !bias_ref_on_o && !dac_power_on_o && !line_driver_on_o)
    else $error("power-down outputs wrong");
  AST_STARTUP_MUTED:
    assert property (power_state_o == PWR_STARTUP
      |-> atten_db_o == ATT_FULL && analog_mute_o && dac_power_on_o && charge_pump_on_o)
    else $error("startup not muted or not powered");
  AST_HARD_MUTE:
    assert property ($rose(atten_db_o == ATT_FULL) && !soft_mute_n_i && power_state_o == PWR_ACTIVE
      |-> ##[1:HM_MAX] (analog_mute_o || soft_mute_n_i))
    else $error("hard mute late after soft ramp");
  AST_GUARD_SHUT:
    assert property (undervoltage_guard_mode_o && !guard_above_lower_i |-> ##[1:8] analog_mute_o)
    else $error("guard lower level did not mute");
  AST_GUARD_PIN:
    assert property ($rose(undervoltage_guard_mode_o) |-> soft_mute_n_i)
    else $error("guard mode entered with pin low");
endmodule

// ### test/dmpm_src_model.sv
// Model of the audio source: system, bit and frame clocks under a run control
`timescale 1ns/100ps
////////////////////////////////////////
module dmpm_src_model (
  // Run control from the bench
  input wire logic run_i,
  // Clock pins toward the device
  output logic sys_clock_o,
  output logic serial_bit_clock_o,
  output logic frame_rate_clock_o
);
  int bit_cnt;
  // Odd start offsets keep the pins out of phase with the core clock
  initial begin
    sys_clock_o = 1'b0;
    #1.3;
    forever begin
      #12;
      sys_clock_o = run_i ? ~sys_clock_o : 1'b0;
    end
  end
  // 32 bit clocks a frame; frame edge on a falling bit edge
  initial begin
    serial_bit_clock_o = 1'b0;
    frame_rate_clock_o = 1'b0;
    bit_cnt = 0;
    #2.9;
    forever begin
      #24;
      if (run_i) begin
        serial_bit_clock_o = ~serial_bit_clock_o;
        if (!serial_bit_clock_o) begin
          bit_cnt = (bit_cnt + 1) % 16;
          if (bit_cnt == 0) begin
            frame_rate_clock_o = ~frame_rate_clock_o;
          end
        end
      end else begin
        // A stopped source rests both clocks low
        serial_bit_clock_o = 1'b0;
        frame_rate_clock_o = 1'b0;
        bit_cnt = 0;
      end
    end
  end
endmodule

// ### test/dmpm_top_tb.sv
// Testbench: power states, soft ramps, clock loss and guard mode
`timescale 1ns/100ps
////////////////////////////////////////
module dmpm_top_tb;
  import dmpm_pkg::*;
  localparam logic [31:0] SL = 32'h0012_3456;
  localparam logic [31:0] SR = 32'h00AB_CDEF;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic run = 1'b0;
  logic smt = 1'b1;
  logic upper = 1'b1;
  logic lower = 1'b1;
  logic [31:0] smp_l = SL;
  logic [31:0] smp_r = SR;
  wire logic sck;
  wire logic serial_bit_clock;
  wire logic frame_rate_clock;
  logic [31:0] hold_l, hold_r;
  logic [6:0] atten;
  logic tick, osc, amute, dac_on, drv_on, pump_on, bias_on, guard;
  dmpm_pwr_t state;
  int num_errors = 0;
  int checks_done = 0;
  int n;

  always #2 mclk_i = ~mclk_i;

  dmpm_src_model u_dmpm_src_model (.run_i(run), .sys_clock_o(sck), .serial_bit_clock_o(serial_bit_clock),
    .frame_rate_clock_o(frame_rate_clock));
  // Short counts keep the run inside the cycle budget
  dmpm_top #(.HALT_CYCLES_P(2000), .GUARD_FALL_CYCLES_P(500), .HARD_MUTE_CYCLES_P(50),
    .FRAME_RATE_CLOCK_TIMEOUT_CYCLES_P(600), .INT_OSC_CYCLES_P(20)) u_dmpm_top (
    .mclk_i(mclk_i), .rst_i(rst_i), .sys_clock_i(sck), .serial_bit_clock_i(serial_bit_clock),
    .frame_rate_clock_i(frame_rate_clock), .soft_mute_n_i(smt), .guard_above_upper_i(upper),
    .guard_above_lower_i(lower), .sample_left_i(smp_l), .sample_right_i(smp_r),
    .hold_left_o(hold_l), .hold_right_o(hold_r), .atten_db_o(atten), .sample_tick_o(tick),
    .internal_osc_sel_o(osc), .analog_mute_o(amute), .dac_power_on_o(dac_on),
    .line_driver_on_o(drv_on), .charge_pump_on_o(pump_on), .bias_ref_on_o(bias_on),
    .undervoltage_guard_mode_o(guard), .power_state_o(state));

  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask

  task automatic hang(input string what);
    num_errors++;
    $display("[FAIL] %s expected event seen timeout", what);
    end_of_test();
  endtask

  // Returns two cycles after a ramp tick so the step has landed
  task automatic tick_wait();
    int k;
    k = 0;
    while (tick !== 1'b1) begin
      if (k++ > 1000) hang("sample tick");
      step(1);
    end
    step(2);
  endtask

  task automatic state_wait(input dmpm_pwr_t s, input int lim);
    int k;
    k = 0;
    while (state !== s) begin
      if (k++ > lim) hang(s.name());
      step(1);
    end
  endtask

  task automatic t_powerup();
    run = 1'b1;
    state_wait(PWR_STARTUP, 3000);
    state_wait(PWR_ACTIVE, 4000);
    chk("power outputs", 32'h0000_000F, {dac_on, drv_on, pump_on, bias_on});
    $display("powerup done");
  endtask

  task automatic t_reverse();
    repeat (3) tick_wait();
    chk("atten after three", ATT_FULL - 7'h03, atten);
    smt = 1'b0;
    tick_wait();
    chk("atten reversed down", ATT_FULL - 7'h02, atten);
    tick_wait();
    chk("atten next step", ATT_FULL - 7'h01, atten);
    smt = 1'b1;
    tick_wait();
    chk("atten reversed up", ATT_FULL - 7'h02, atten);
    n = 0;
    while (atten !== ATT_NONE) begin
      if (n > 120) hang("ramp up");
      tick_wait();
      n++;
    end
    chk("ticks to full scale", ATT_FULL - 7'h02, n);
    chk("mute released", 0, amute);
    $display("reverse done");
  endtask

  task automatic t_soft_mute();
    smt = 1'b0;
    // Silent input for the whole ramp, far short of the zero-detect count
    smp_l = 32'h0;
    smp_r = 32'h0;
    n = 0;
    while (atten !== ATT_FULL) begin
      if (n > 120) hang("ramp down");
      tick_wait();
      n++;
    end
    chk("ticks to silence", ATT_FULL, n);
    chk("mute not early", 0, amute);
    step(58);
    chk("hard mute", 1, amute);
    $display("soft mute done");
  endtask

  task automatic t_clock_loss();
    smt = 1'b1;
    smp_l = SL;
    smp_r = SR;
    repeat (5) tick_wait();
    chk("atten before loss", ATT_FULL - 7'h05, atten);
    run = 1'b0;
    n = 0;
    while (osc !== 1'b1) begin
      if (n++ > 1000) hang("internal osc");
      step(1);
    end
    chk("held left", SL, hold_l);
    chk("held right", SR, hold_r);
    state_wait(PWR_STANDBY, 300);
    chk("atten silent", ATT_FULL, atten);
    // Analog mute is registered, so it follows the state by one cycle
    step(1);
    chk("standby outputs", 32'h0000_001C, {amute, pump_on, bias_on, dac_on, drv_on});
    state_wait(PWR_DOWN, 2500);
    chk("down outputs", 32'h0000_0010, {amute, pump_on, bias_on, dac_on, drv_on});
    run = 1'b1;
    state_wait(PWR_ACTIVE, 6000);
    $display("clock loss done");
  endtask

  task automatic t_guard();
    upper = 1'b0;
    step(100);
    smt = 1'b0;
    step(600);
    chk("fast fall", 0, guard);
    smt = 1'b1;
    upper = 1'b1;
    step(10);
    upper = 1'b0;
    step(600);
    chk("slow fall", 1, guard);
    lower = 1'b0;
    state_wait(PWR_STANDBY, 20);
    chk("guard mute", 1, amute);
    lower = 1'b1;
    upper = 1'b1;
    step(10);
    chk("guard cleared", 0, guard);
    $display("guard done");
  endtask

  initial begin
    step(4);
    rst_i = 1'b0;
    t_powerup();
    t_reverse();
    t_soft_mute();
    t_clock_loss();
    t_guard();
    end_of_test();
  end
endmodule

bind dmpm_top dmpm_checker #(.HARD_MUTE_CYCLES_P(HARD_MUTE_CYCLES_P)) u_dmpm_checker (
  .mclk_i(mclk_i), .rst_i(rst_i), .soft_mute_n_i(soft_mute_n_i),
  .guard_above_lower_i(guard_above_lower_i), .atten_db_o(atten_db_o),
  .sample_tick_o(sample_tick_o), .internal_osc_sel_o(internal_osc_sel_o),
  .analog_mute_o(analog_mute_o), .dac_power_on_o(dac_power_on_o),
  .line_driver_on_o(line_driver_on_o), .charge_pump_on_o(charge_pump_on_o),
  .bias_ref_on_o(bias_ref_on_o), .undervoltage_guard_mode_o(undervoltage_guard_mode_o),
  .power_state_o(power_state_o));
